// File: rtl/sclr_pkg.sv
// Constants for the serial clock selection and receive path.
// Assumes a 32-bit APB slave port and one 50 MHz system clock.
`default_nettype none

package sclr_pkg;

    // Register byte offsets
    localparam logic [7:0] SCLR_OFS_CTRL = 8'h00;
    localparam logic [7:0] SCLR_OFS_DIV = 8'h04;
    localparam logic [7:0] SCLR_OFS_DATA = 8'h08;
    localparam logic [7:0] SCLR_OFS_STAT = 8'h0C;

    // Control register fields
    localparam int SCLR_CTRL_RXEN = 0;
    localparam int SCLR_CTRL_IOMODE = 1;
    localparam int SCLR_CTRL_SRC_LO = 2;
    localparam int SCLR_CTRL_DIR = 4;
    localparam int SCLR_CTRL_EDGE = 5;
    localparam int SCLR_CTRL_CHAR8 = 6;
    localparam int SCLR_CTRL_FDX = 7;
    localparam int SCLR_CTRL_PRE_LO = 8;
    localparam int SCLR_CTRL_W = 10;
    localparam logic [9:0] SCLR_CTRL_RST = 10'h040;

    // Divider register fields
    localparam int SCLR_DIV_N_LO = 0;
    localparam int SCLR_DIV_K_LO = 4;
    localparam int SCLR_DIV_FRAC = 8;
    localparam int SCLR_DIV_W = 9;
    localparam logic [8:0] SCLR_DIV_RST = 9'h001;

    // Status register fields
    localparam int SCLR_STAT_FULL = 0;
    localparam int SCLR_STAT_OVR = 1;
    localparam int SCLR_STAT_BUSY = 2;

    // UART source select codes
    localparam logic [1:0] SCLR_SRC_BRG = 2'h0;
    localparam logic [1:0] SCLR_SRC_HALF = 2'h1;
    localparam logic [1:0] SCLR_SRC_TMR = 2'h2;
    localparam logic [1:0] SCLR_SRC_PIN = 2'h3;

    // Oversampling: 16 base clocks per bit, votes on 7th to 9th
    localparam logic [3:0] SCLR_SMP_FIRST = 4'h6;
    localparam logic [3:0] SCLR_SMP_MID = 4'h7;
    localparam logic [3:0] SCLR_SMP_LAST = 4'h8;
    localparam logic [3:0] SCLR_BIT_END = 4'hF;
    localparam logic [4:0] SCLR_FRAC_ONE = 5'h10;
    localparam logic [3:0] SCLR_IO_BITS = 4'h8;
    localparam logic [3:0] SCLR_LEN7 = 4'h7;

    // UART receive states
    typedef enum logic [1:0] {
        SCLR_RX_IDLE,
        SCLR_RX_START,
        SCLR_RX_DATA,
        SCLR_RX_STOP
    } sclr_rx_state_t;

endpackage

`default_nettype wire

// File: rtl/sclr_top.sv
// Serial clock generation and receive path with a double receive buffer.
// Assumes an APB master on mclk, prescaler tap and timer trigger pulses
// on mclk, and asynchronous serial pins.
//
// Operation
// - External clock UART: bit rate is clock/16
// - I/O external clock: one bit per cycle
// - Timer trigger never a source in I/O
// - Timer rate: input/(compare x 2 x 16)
// - I/O output clock: halve divider output
// - I/O input clock: pin clock, chosen edge
// - UART base clock from four-way select
// - Four-bit counter spans 16 clocks per bit
// - Vote on 7th, 8th and 9th clocks
// - Sampling starts only after valid start
// - Driven clock: sample on rising edge
// - Input clock: sample on selected edge
// - Full character moves to buffer two, interrupt
// - I/O double buffering only in full duplex
// - Integer divide by N, 1 to 16
// - Fractional divide N plus (16-K)/16
//
// Register access over APB and the placing of the registers were left to the implementer.
`default_nettype none

module sclr_top
    import sclr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] prescaler_tap,
    input wire logic timer_trigger,
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe,
    input wire logic receive_data_pin,
    output logic receive_done_interrupt
);
    import sclr_pkg::*;

    // Two-of-three majority vote
    function automatic logic maj3(input logic a, input logic b,
                                  input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    // Software visible registers
    logic [SCLR_CTRL_W-1:0] ctrl_q;
    logic [SCLR_DIV_W-1:0] div_q;
    logic [7:0] rx_buf_two_q;
    logic full_q;
    logic ovr_q;
    logic [31:0] prdata_q;

    // Control and divider field views
    wire rx_en = ctrl_q[SCLR_CTRL_RXEN];
    wire io_mode = ctrl_q[SCLR_CTRL_IOMODE];
    wire [1:0] serial_clock_source_select =
        ctrl_q[SCLR_CTRL_SRC_LO +: 2];
    wire clock_pin_direction = ctrl_q[SCLR_CTRL_DIR];
    wire clock_edge_select = ctrl_q[SCLR_CTRL_EDGE];
    wire char8 = ctrl_q[SCLR_CTRL_CHAR8];
    wire full_duplex = ctrl_q[SCLR_CTRL_FDX];
    wire [1:0] prescaler_clock_select = ctrl_q[SCLR_CTRL_PRE_LO +: 2];
    wire [3:0] integer_divisor = div_q[SCLR_DIV_N_LO +: 4];
    wire [3:0] fraction_value = div_q[SCLR_DIV_K_LO +: 4];
    wire fractional_divide_enable = div_q[SCLR_DIV_FRAC];

    // APB decode
    wire setup_ph = psel & ~penable;
    wire access_ph = psel & penable;
    wire hit_ctrl = (paddr == SCLR_OFS_CTRL);
    wire hit_div = (paddr == SCLR_OFS_DIV);
    wire hit_data = (paddr == SCLR_OFS_DATA);
    wire hit_stat = (paddr == SCLR_OFS_STAT);
    wire hit_any = hit_ctrl | hit_div | hit_data | hit_stat;
    wire wr_ctrl = access_ph & pwrite & hit_ctrl;
    wire wr_div = access_ph & pwrite & hit_div;
    wire rd_data = access_ph & ~pwrite & hit_data;

    // Slave always answers in the first access cycle
    assign pready = penable;
    assign pslverr = access_ph & ~hit_any;
    assign prdata = prdata_q;

    // Pin synchronisers
    logic sck_s1_q;
    logic sck_s2_q;
    logic sck_s3_q;
    logic rxd_s1_q;
    logic rxd_s2_q;

    // Two flops per pin, third flop only for edge finding
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sck_s1_q <= 1'b1;
            sck_s2_q <= 1'b1;
            sck_s3_q <= 1'b1;
            rxd_s1_q <= 1'b1;
            rxd_s2_q <= 1'b1;
        end else begin
            sck_s1_q <= serial_clock_pin_i;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            rxd_s1_q <= receive_data_pin;
            rxd_s2_q <= rxd_s1_q;
        end
    end

    // Edges of the synchronised clock pin
    wire pin_rise = sck_s2_q & ~sck_s3_q;
    wire pin_fall = ~sck_s2_q & sck_s3_q;
    wire rxd = rxd_s2_q;

    // Divider input: one of four prescaler tap pulses
    wire tap_en = prescaler_tap[prescaler_clock_select];

    // Divider state
    logic [3:0] div_cnt_q;
    logic [3:0] frac_acc_q;
    logic extra_q;
    logic brg_tick;

    // Fraction honoured only in UART mode
    wire frac_on = fractional_divide_enable & ~io_mode;
    // Zero in the divisor field means 16
    wire [4:0] n_full = (integer_divisor == 4'h0) ?
        SCLR_FRAC_ONE : {1'b0, integer_divisor};
    // Period grows by one whenever the fraction overflows
    wire [4:0] period = n_full + {4'h0, extra_q & frac_on};
    wire [4:0] frac_sum = {1'b0, frac_acc_q} +
        (SCLR_FRAC_ONE - {1'b0, fraction_value});
    wire div_wrap = tap_en & ({1'b0, div_cnt_q} == period - 5'h01);
    assign brg_tick = div_wrap;

    // Counts tap pulses, carries fraction between periods
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_q <= 4'h0;
            frac_acc_q <= 4'h0;
            extra_q <= 1'b0;
        end else if (div_wrap) begin
            div_cnt_q <= 4'h0;
            frac_acc_q <= frac_on ? frac_sum[3:0] : 4'h0;
            extra_q <= frac_on & frac_sum[4];
        end else if (tap_en) begin
            div_cnt_q <= div_cnt_q + 4'h1;
        end
    end

    // Half system clock and halved timer trigger
    logic half_q;
    logic tmr_tgl_q;

    // Timer trigger halved before the 16x oversampling
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            half_q <= 1'b0;
            tmr_tgl_q <= 1'b0;
        end else begin
            half_q <= ~half_q;
            if (timer_trigger) begin
                tmr_tgl_q <= ~tmr_tgl_q;
            end
        end
    end
    wire tmr_tick = timer_trigger & tmr_tgl_q;

    // UART base clock select; external pin feeds the x16 count
    logic uart_base;
    always_comb begin
        unique case (serial_clock_source_select)
            SCLR_SRC_BRG: uart_base = brg_tick;
            SCLR_SRC_HALF: uart_base = half_q;
            SCLR_SRC_TMR: uart_base = tmr_tick;
            SCLR_SRC_PIN: uart_base = pin_rise;
        endcase
    end
    // Source select is not consulted in I/O mode
    wire serial_base_clock = rx_en & ~io_mode & uart_base;

    // I/O mode shift clock and receive shifter
    logic sck_out_q;
    logic [3:0] io_bits_q;
    // Half duplex waits for buffer two to be read
    wire io_hold = ~full_duplex & full_q;
    wire io_drive = rx_en & io_mode & ~clock_pin_direction;
    // Output clock toggles on each divider tick
    wire io_tgl = io_drive & ~io_hold & brg_tick;
    // Own clock: sample at its rising edge
    wire io_own_smp = io_tgl & ~sck_out_q;
    // Pin clock: sample at the chosen edge
    wire io_pin_smp = rx_en & io_mode & clock_pin_direction & ~io_hold &
        (clock_edge_select ? pin_fall : pin_rise);
    // One received bit per shift clock cycle
    wire io_smp = io_own_smp | io_pin_smp;

    // Driven clock idles high
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sck_out_q <= 1'b1;
        end else if (!io_drive) begin
            sck_out_q <= 1'b1;
        end else if (io_tgl) begin
            sck_out_q <= ~sck_out_q;
        end
    end
    assign serial_clock_pin_o = sck_out_q;
    assign serial_clock_pin_oe = io_drive;

    // UART receive sequencer
    sclr_rx_state_t st_q;
    logic [3:0] tick_q;
    logic [1:0] smp_q;
    logic [3:0] bit_q;
    logic [7:0] rx_buf_one_q;

    // Vote taken on the third sample
    wire vote = maj3(smp_q[0], smp_q[1], rxd);
    wire at_vote = serial_base_clock & (tick_q == SCLR_SMP_LAST);
    wire at_end = serial_base_clock & (tick_q == SCLR_BIT_END);
    wire [3:0] char_len = char8 ? SCLR_IO_BITS : SCLR_LEN7;

    // Character complete in either mode
    wire uart_done = at_vote & (st_q == SCLR_RX_STOP);
    wire io_done = io_smp & (io_bits_q == SCLR_IO_BITS - 4'h1);
    wire load = uart_done | io_done;
    wire [7:0] io_next = {rxd, rx_buf_one_q[7:1]};
    // Seven-bit characters sit one place high in the shifter
    wire [7:0] load_val = io_done ? io_next :
        (char8 ? rx_buf_one_q : {1'b0, rx_buf_one_q[7:1]});

    // Four-bit counter wraps every 16 base clocks
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_q <= 4'h0;
        end else if (st_q == SCLR_RX_IDLE) begin
            // Counter held at zero until a start edge
            tick_q <= 4'h0;
        end else if (serial_base_clock) begin
            tick_q <= tick_q + 4'h1;
        end
    end

    // First two of the three samples
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            smp_q <= 2'h0;
        end else if (serial_base_clock && tick_q == SCLR_SMP_FIRST) begin
            smp_q[0] <= rxd;
        end else if (serial_base_clock && tick_q == SCLR_SMP_MID) begin
            smp_q[1] <= rxd;
        end
    end

    // State walk from start bit to stop bit
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= SCLR_RX_IDLE;
            bit_q <= 4'h0;
        end else if (!rx_en || io_mode) begin
            st_q <= SCLR_RX_IDLE;
            bit_q <= 4'h0;
        end else begin
            unique case (st_q)
                SCLR_RX_IDLE: begin
                    // Low line on a base clock opens a start bit
                    if (serial_base_clock && !rxd) begin
                        st_q <= SCLR_RX_START;
                    end
                    bit_q <= 4'h0;
                end
                SCLR_RX_START: begin
                    // Voted high start is a glitch
                    if (at_vote && vote) begin
                        st_q <= SCLR_RX_IDLE;
                    end else if (at_end) begin
                        st_q <= SCLR_RX_DATA;
                    end
                end
                SCLR_RX_DATA: begin
                    if (at_vote) begin
                        bit_q <= bit_q + 4'h1;
                    end
                    if (at_end && bit_q == char_len) begin
                        st_q <= SCLR_RX_STOP;
                    end
                end
                SCLR_RX_STOP: begin
                    // Hand over at mid stop bit, then hunt again
                    if (at_vote) begin
                        st_q <= SCLR_RX_IDLE;
                    end
                end
            endcase
        end
    end

    // Buffer one: shifts LSB first in both modes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_buf_one_q <= 8'h00;
        end else if (io_smp) begin
            rx_buf_one_q <= io_next;
        end else if (at_vote && st_q == SCLR_RX_DATA) begin
            rx_buf_one_q <= {vote, rx_buf_one_q[7:1]};
        end
    end

    // I/O bit counter
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            io_bits_q <= 4'h0;
        end else if (!io_mode || !rx_en || io_done) begin
            io_bits_q <= 4'h0;
        end else if (io_smp) begin
            io_bits_q <= io_bits_q + 4'h1;
        end
    end

    // Transfer to buffer two; overrun keeps the old character
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_buf_two_q <= 8'h00;
            full_q <= 1'b0;
            ovr_q <= 1'b0;
            receive_done_interrupt <= 1'b0;
        end else begin
            receive_done_interrupt <= load & ~full_q;
            if (load && !full_q) begin
                rx_buf_two_q <= load_val;
            end
            // A new character beats a read in the same cycle
            if (load) begin
                full_q <= 1'b1;
            end else if (rd_data) begin
                full_q <= 1'b0;
            end
            if (load && full_q) begin
                ovr_q <= 1'b1;
            end else if (rd_data) begin
                ovr_q <= 1'b0;
            end
        end
    end

    // Configuration writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= SCLR_CTRL_RST;
            div_q <= SCLR_DIV_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata[SCLR_CTRL_W-1:0];
            end
            if (wr_div) begin
                div_q <= pwdata[SCLR_DIV_W-1:0];
            end
        end
    end

    // Status word
    wire busy = (st_q != SCLR_RX_IDLE) | (io_bits_q != 4'h0);
    wire [31:0] stat_word = {29'h0, busy, ovr_q, full_q};

    // Read data captured in the setup cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h0;
        end else if (setup_ph && !pwrite) begin
            prdata_q <= hit_ctrl ? {22'h0, ctrl_q} :
                hit_div ? {23'h0, div_q} :
                hit_data ? {24'h0, rx_buf_two_q} :
                hit_stat ? stat_word : 32'h0;
        end
    end

endmodule

`default_nettype wire

// File: tb/sclr_checker.sv
// Port checker for the serial clock and receive block.
// Assumes it is bound to sclr_top and sees only its ports.
`default_nettype none

module sclr_checker
    import sclr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] prescaler_tap,
    input wire logic timer_trigger,
    input wire logic serial_clock_pin_i,
    input wire logic serial_clock_pin_o,
    input wire logic serial_clock_pin_oe,
    input wire logic receive_data_pin,
    input wire logic receive_done_interrupt
);
    timeunit 1ns;
    timeprecision 1ns;

    // Shadow control word and buffer-two state
    logic [9:0] ctrl_q;
    logic full_q;
    // Access-phase decodes
    wire acc = psel && penable;
    wire ctl_wr = acc && pwrite && paddr == SCLR_OFS_CTRL;
    wire buf_rd = acc && !pwrite && paddr == SCLR_OFS_DATA;
    wire unmapped = !(paddr inside {SCLR_OFS_CTRL, SCLR_OFS_DIV,
        SCLR_OFS_DATA, SCLR_OFS_STAT});

    // Follow control writes and buffer fill as software sees them
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= SCLR_CTRL_RST;
            full_q <= 1'b0;
        end else begin
            if (ctl_wr) begin
                ctrl_q <= pwdata[9:0];
            end
            full_q <= receive_done_interrupt || (full_q && !buf_rd);
        end
    end

    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    apb_ready_a:
        assert property (pready == penable)
        else $error("ready not equal to enable");
    apb_error_a:
        assert property (pslverr == (acc && unmapped))
        else $error("error response wrong");
    read_hold_a:
        assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved outside a read");
    irq_pulse_a:
        assert property (receive_done_interrupt |=> !receive_done_interrupt)
        else $error("interrupt longer than one cycle");
    irq_enable_a:
        assert property (receive_done_interrupt |-> ctrl_q[SCLR_CTRL_RXEN])
        else $error("interrupt while receiver off");
    stop_high_a:
        assert property (receive_done_interrupt && !ctrl_q[SCLR_CTRL_IOMODE]
            |-> $past(receive_data_pin, 4))
        else $error("character done without high stop");
    pin_drive_a:
        assert property (serial_clock_pin_oe == (ctrl_q[SCLR_CTRL_RXEN] &&
            ctrl_q[SCLR_CTRL_IOMODE] && !ctrl_q[SCLR_CTRL_DIR]))
        else $error("clock pin drive wrong");
    half_stop_a:
        assert property (serial_clock_pin_oe && !ctrl_q[SCLR_CTRL_FDX] &&
            full_q && !buf_rd |=> $stable(serial_clock_pin_o))
        else $error("clock ran while buffer full");

    // Main scenarios reached
    cover property (receive_done_interrupt && !ctrl_q[SCLR_CTRL_IOMODE]);
    cover property (receive_done_interrupt && ctrl_q[SCLR_CTRL_IOMODE]);
    cover property (pslverr);
endmodule

bind sclr_top sclr_checker u_sclr_checker (.mclk(mclk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prescaler_tap(prescaler_tap), .timer_trigger(timer_trigger),
    .serial_clock_pin_i(serial_clock_pin_i),
    .serial_clock_pin_o(serial_clock_pin_o),
    .serial_clock_pin_oe(serial_clock_pin_oe),
    .receive_data_pin(receive_data_pin),
    .receive_done_interrupt(receive_done_interrupt));

`default_nettype wire

// File: tb/sclr_remote.sv
// Remote serial device driving the data and clock pins.
// Assumes the bench calls one task at a time.
`default_nettype none

module sclr_remote (
    input wire logic mclk,
    input wire logic dev_clk,
    output logic line,
    output logic clk_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // Lines idle high
    initial begin
        line = 1'b1;
        clk_out = 1'b1;
    end

    // UART frame, LSB first, with an idle bit either side
    task automatic uart(input logic [7:0] b, input int bitc, input bit ext);
        logic [11:0] f;
        f = {2'b11, b, 1'b0, 1'b1};
        for (int i = 0; i < 12; i++) begin
            line <= f[i];
            for (int c = 0; c < bitc; c++) begin
                if (ext) clk_out <= c[1];
                @(posedge mclk);
            end
        end
        clk_out <= 1'b1;
    endtask

    // Low pulse too short to be a start bit
    task automatic glitch(input int n);
        line <= 1'b0;
        repeat (n) @(posedge mclk);
        line <= 1'b1;
    endtask

    // Eight bits on our clock; data flips after the chosen edge
    task automatic io(input logic [7:0] b, input bit fall);
        for (int i = 0; i < 8; i++) begin
            clk_out <= fall;
            repeat (5) @(posedge mclk);
            line <= b[i];
            repeat (5) @(posedge mclk);
            clk_out <= !fall;
            repeat (5) @(posedge mclk);
            line <= !b[i];
            repeat (5) @(posedge mclk);
        end
        clk_out <= 1'b1;
        line <= 1'b1;
    endtask

    // Eight bits set after each fall of the device clock
    task automatic io_dev(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(negedge dev_clk);
            line <= b[i];
            @(posedge dev_clk);
            repeat (3) @(posedge mclk);
            line <= !b[i];
        end
        // Let an edge pass so the line changes once per step
        @(posedge mclk);
        line <= 1'b1;
    endtask
endmodule

`default_nettype wire

// File: tb/tb_sclr_top.sv
// Self-checking bench for the serial clock and receive block.
// Assumes the remote model and the checker are compiled first.
`default_nettype none

module tb_sclr_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sclr_pkg::*;

    logic mclk, rst_n, psel, penable, pwrite, timer_trigger, er;
    logic pready, pslverr, sclk_o, sclk_oe, rxd, irq, rclk, s;
    logic [7:0] paddr, b0;
    logic [31:0] pwdata, prdata, rd, v;
    logic [3:0] prescaler_tap;
    int n_fail, checks, n_irq, cnt, n0, n, p;
    // Shared clock pin level
    wire sclk_in = sclk_oe ? sclk_o : rclk;

    sclr_top u_sclr_top (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .prescaler_tap(prescaler_tap), .timer_trigger(timer_trigger),
        .serial_clock_pin_i(sclk_in), .serial_clock_pin_o(sclk_o),
        .serial_clock_pin_oe(sclk_oe), .receive_data_pin(rxd),
        .receive_done_interrupt(irq));
    sclr_remote u_sclr_remote (.mclk(mclk), .dev_clk(sclk_o), .line(rxd),
        .clk_out(rclk));

    // System clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Taps every 1, 4, 16, 64 cycles; timer match every 3; irq count
    always @(posedge mclk) begin
        cnt <= cnt + 1;
        prescaler_tap <= {cnt[5:0] == 0, cnt[3:0] == 0, cnt[1:0] == 0, 1'b1};
        timer_trigger <= cnt % 3 == 0;
        if (irq === 1'b1) n_irq <= n_irq + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; answer kept in rd and er
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // One random UART character through the chosen clock source
    task automatic urx(input logic [9:0] c, input logic [8:0] dv,
                       input int bitc, input bit ext);
        logic [7:0] b;
        b = 8'($urandom);
        if (!c[SCLR_CTRL_CHAR8]) b[7] = 1'b1;
        apb(1'b1, SCLR_OFS_DIV, {23'h0, dv});
        apb(1'b1, SCLR_OFS_CTRL, {22'h0, c});
        n0 = n_irq;
        u_sclr_remote.uart(b, bitc, ext);
        chk(32'(n_irq - n0), 32'h1);
        rdchk(SCLR_OFS_STAT, 32'h1);
        rdchk(SCLR_OFS_DATA, {24'h0, (c[6] ? b : {1'b0, b[6:0]})});
        rdchk(SCLR_OFS_STAT, 32'h0);
    endtask

    task automatic results;
        if (n_fail == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #1900000;
        n_fail++;
        results();
    end

    initial begin
        {rst_n, psel, penable, pwrite, timer_trigger} = 5'h00;
        {paddr, pwdata, prescaler_tap} = 44'h0;
        {cnt, n_irq, n_fail, checks} = '0;
        void'($urandom(134));
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        // Reset values, unmapped and read-only places
        rdchk(SCLR_OFS_CTRL, 32'h40);
        rdchk(SCLR_OFS_DIV, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        // Receiver kept off so no stray character lands in buffer two
        v = $urandom & 32'hFFFFFFFE;
        apb(1'b1, SCLR_OFS_CTRL, v);
        rdchk(SCLR_OFS_CTRL, v & 32'h3FF);
        apb(1'b1, SCLR_OFS_STAT, 32'hFF);
        rdchk(SCLR_OFS_STAT, 32'h0);
        // UART on half system clock, 8 and 7 bits
        urx(10'h045, 9'h001, 32, 0);
        urx(10'h005, 9'h001, 32, 0);
        // Integer divisor, 0 standing for 16, on two taps
        for (int k = 0; k < 3; k++) begin
            n = (k == 0) ? 0 : 2 + $urandom % 4;
            p = (k == 0) ? 0 : $urandom % 2;
            urx({p[1:0], 8'h41}, {5'h0, n[3:0]},
                16 * (n == 0 ? 16 : n) * (p != 0 ? 4 : 1), 0);
        end
        urx(10'h041, 9'h137, 125, 0);
        urx(10'h049, 9'h001, 96, 0);
        urx(10'h04D, 9'h001, 64, 1);
        // Second character while the first is unread
        apb(1'b1, SCLR_OFS_CTRL, 32'h45);
        n0 = n_irq;
        b0 = 8'($urandom);
        u_sclr_remote.uart(b0, 32, 0);
        u_sclr_remote.uart(8'($urandom), 32, 0);
        chk(32'(n_irq - n0), 32'h1);
        rdchk(SCLR_OFS_STAT, 32'h3);
        rdchk(SCLR_OFS_DATA, {24'h0, b0});
        // Short low pulse starts nothing
        u_sclr_remote.glitch(4);
        repeat (400) @(posedge mclk);
        chk(32'(n_irq - n0), 32'h1);
        rdchk(SCLR_OFS_STAT, 32'h0);
        // I/O mode on the pin clock, timer source ignored
        apb(1'b1, SCLR_OFS_DIV, 32'h8);
        for (int e = 0; e < 2; e++) begin
            apb(1'b1, SCLR_OFS_CTRL, 32'hDB | (e << 5));
            n0 = n_irq;
            b0 = 8'($urandom);
            u_sclr_remote.io(b0, e[0]);
            repeat (10) @(posedge mclk);
            chk(32'(n_irq - n0), 32'h1);
            rdchk(SCLR_OFS_DATA, {24'h0, b0});
        end
        // I/O mode on our own clock, half duplex
        apb(1'b1, SCLR_OFS_CTRL, 32'h43);
        // Drive enable changes on the edge the write lands; checked one edge later
        @(posedge mclk);
        chk({31'h0, sclk_oe}, 32'h1);
        b0 = 8'($urandom);
        u_sclr_remote.io_dev(b0);
        repeat (40) @(posedge mclk);
        s = sclk_o;
        repeat (40) @(posedge mclk);
        chk({31'h0, sclk_o}, {31'h0, s});
        rdchk(SCLR_OFS_STAT, 32'h1);
        rdchk(SCLR_OFS_DATA, {24'h0, b0});
        apb(1'b1, SCLR_OFS_CTRL, 32'h40);
        results();
    end
endmodule

`default_nettype wire
